// ---- siu_host_model.sv ----
// Purpose: Host side model, register reader and attention pin pull-up
// Assumes: Bench calls rd on the falling edge of sys_clk
// Notes: A released pin floats high through the pull-up
module siu_host_model (
	input wire logic sys_clk, // System clock
	input wire logic attn_out, // Device pin value
	input wire logic attn_oe, // Device pin enable
	input wire logic cfg_en, // Host drives the config level
	input wire logic cfg_level, // Config level on the pin
	input wire logic [7:0] rd_data, // Read data from the device
	output logic attn_pin, // Resolved pin level
	output logic rd_only, // Read-only strobe
	output logic [2:0] rd_addr // Read-only address
);
	timeunit 1ns;
	timeprecision 1ps;
	assign attn_pin = attn_oe ? attn_out : (cfg_en ? cfg_level : 1'b1);
	initial begin
		rd_only = 1'b0;
		rd_addr = 3'h0;
	end
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		rd_only = 1'b1;
		rd_addr = a;
		@(negedge sys_clk);
		rd_only = 1'b0;
		rd_addr = ~a;
		@(negedge sys_clk);
		d = rd_data;
	endtask : rd
endmodule : siu_host_model

// ---- siu_interrupt_unit.sv ----
// Purpose: Attention-line interrupt unit with latched flags and masks
// Assumes: Source levels come from logic on sys_clk; only the pin is synced
// Notes: Attention pin is open drain; low is driven while attn_oe is high
// Overview of operation
// R1: Unmasked active source pulls attention line low
// R2: Mask blocks pin only; flag still set
// R3: Supply undervoltage triggers on appear and disappear
// R4: State flags latch until read, then follow
// R5: Chip-failure and wake flags are pure events
// R6: Register 0 read or timeout releases line
// R7: Wake flags in register 0, cleared on read
// R8: Summary flag points host to registers 1, 2
// R9: Read clears event flags of that register
// R10: Summary clears only when registers 1, 2 zero
// R11: Before reset release, pin selects configuration
// R12: No switch-off interrupt; switch-on raises flag
// R13: Switch-on flag sticks while supply still low
// R14: Release of undervoltage may interrupt again
// R15: Reset source active only in development mode
// R16: All timing from on-chip oscillator clock
// R17: Host releases line by reading register 0
// R18: Timeout bounds low time and activation spacing
// R19: Low pulse lasts at least ten microseconds
// R20: Restart re-enables every interrupt source
// R21: Several sources before read give one pulse
module siu_interrupt_unit #(
	parameter int TIMEOUT_CYCLES = siu_pkg::TIMEOUT_CYC // Attention timeout in clocks
) (
	input wire logic sys_clk, // System clock, 25 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic reset_line_n, // Reset output level, low during init
	input wire logic sw_dev_mode, // Software development mode active
	input wire logic restart_mode, // Chip in restart mode
	input wire logic bus_wake_flag, // Bus wake event
	input wire logic single_wire_wake_flag, // Single-wire bus wake event
	input wire logic local_pin_wake_flag, // Local wake pin event
	input wire logic periodic_wake_flag, // Periodic wake event
	input wire logic prewarn_temp, // Main supply thermal prewarning
	input wire logic thermal_shutdown_flag, // Aux supply over-temperature
	input wire logic bus_transceiver_overheat, // Transceiver over-temperature
	input wire logic bus_fault, // Bus transceiver failure
	input wire logic single_wire_fault_flag, // Single-wire transceiver failure
	input wire logic third_supply_overcurrent, // Third supply overcurrent
	input wire logic aux_supply_low_flag, // Aux supply undervoltage level
	input wire logic third_supply_low_flag, // Third supply undervoltage level
	input wire logic aux_supply_on, // Pulse: aux supply switched on
	input wire logic aux_supply_off, // Pulse: aux supply switched off
	input wire logic third_supply_on, // Pulse: third supply switched on
	input wire logic third_supply_off, // Pulse: third supply switched off
	input wire logic spi_frame_bad, // Pulse: corrupted serial frame
	input wire logic bad_guard_config_flag, // Pulse: bad watchdog setting
	input wire logic rd_only, // Pulse: read-only access
	input wire logic [2:0] rd_addr, // Register of the read-only access
	output logic [7:0] rd_data, // Read data, valid cycle after rd_only
	input wire logic mask_wr, // Pulse: mask register write
	input wire logic [2:0] mask_addr, // Mask register address
	input wire logic [7:0] mask_wdata, // Mask value, 1 enables the source
	input wire logic attn_in, // Attention pin level
	output logic attn_out, // Attention pin drive value
	output logic attn_oe, // Attention pin drive enable
	output logic cfg_alt // Configuration 2/4 selected
);
	import siu_pkg::*;

	localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
	localparam logic [CNT_W-1:0] MIN_LAST = CNT_W'(MIN_PULSE_CYC - 1);

	function automatic logic [7:0] rising(input logic [7:0] now, input logic [7:0] was);
		rising = now & ~was;
	endfunction : rising

	siu_state_e state;
	logic [CNT_W-1:0] cnt;
	logic pend, rel_req;
	logic pin_meta, pin_sync;
	logic [1:0] supply_en;
	logic [WAKE_W-1:0] wk_now, wk_q, wk_rise, f0, m0;
	logic [FA_W-1:0] fa_now, fa_q, fa_rise, f1, m1;
	logic [FB_W-1:0] fb_now, fb_q, fb_rise, fb_trig, f2, m2;
	logic [FB_UV_W-1:0] uv_eff, uv_fall, sup_on, sup_off;
	logic rd0, rd1, rd2, summary, trig, active;
	logic [7:0] next_rd_data;

	assign active = reset_line_n;
	assign rd0 = rd_only && rd_addr == ADDR_WAKE_SUM;
	assign rd1 = rd_only && rd_addr == ADDR_FAULT_A;
	assign rd2 = rd_only && rd_addr == ADDR_FAULT_B;
	assign sup_on = {third_supply_on, aux_supply_on};
	assign sup_off = {third_supply_off, aux_supply_off};
	assign uv_eff = {third_supply_low_flag, aux_supply_low_flag} & supply_en; // R12

	assign wk_now = {periodic_wake_flag, local_pin_wake_flag, single_wire_wake_flag,
		bus_wake_flag};
	assign fa_now = {third_supply_overcurrent, single_wire_fault_flag, bus_fault,
		bus_transceiver_overheat, thermal_shutdown_flag, prewarn_temp};
	assign fb_now = {bad_guard_config_flag, ~reset_line_n & sw_dev_mode, spi_frame_bad,
		uv_eff}; // R15

	assign wk_rise = WAKE_W'(rising(8'(wk_now), 8'(wk_q)));
	assign fa_rise = FA_W'(rising(8'(fa_now), 8'(fa_q)));
	assign fb_rise = FB_W'(rising(8'(fb_now), 8'(fb_q)));
	assign uv_fall = FB_UV_W'(rising(8'(fb_q[FB_UV_W-1:0]), 8'(uv_eff))) & supply_en; // R3 R14
	assign fb_trig = fb_rise | {3'b000, uv_fall | sup_on}; // R3 R12
	assign trig = active && (|(wk_rise & m0) || |(fa_rise & m1) || |(fb_trig & m2)); // R1 R2
	assign summary = |f1 || |f2; // R8 R10

	// Previous source levels for edge detection
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wk_q <= '0;
			fa_q <= '0;
			fb_q <= '0;
		end else begin
			wk_q <= wk_now;
			fa_q <= fa_now;
			fb_q <= fb_now;
		end
	end

	// Supply enable tracking, switch-off hides undervoltage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			supply_en <= '0;
		end else begin
			supply_en <= (supply_en & ~sup_off) | sup_on; // R12
		end
	end

	// Wake flags: events, cleared by register 0 read, set wins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			f0 <= WAKE_W'(FLAG_RESET);
		end else begin
			f0 <= wk_rise | (f0 & ~{WAKE_W{rd0}}); // R5 R7 R9
		end
	end

	// Fault A flags: latched at event, follow state after read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			f1 <= FA_W'(FLAG_RESET);
		end else begin
			f1 <= fa_rise | (rd1 ? fa_now : f1); // R4 R9
		end
	end

	// Fault B flags: supply lows latch, others are events
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			f2 <= FB_W'(FLAG_RESET);
		end else begin
			f2[FB_UV_W-1:0] <= fb_rise[FB_UV_W-1:0] | sup_on
				| (rd2 ? uv_eff : f2[FB_UV_W-1:0]); // R4 R12 R13
			f2[FB_W-1:FB_UV_W] <= fb_rise[FB_W-1:FB_UV_W]
				| (f2[FB_W-1:FB_UV_W] & ~{(FB_W-FB_UV_W){rd2}}); // R5 R9
		end
	end

	// Masks, re-enabled on restart
	always_ff @(posedge sys_clk) begin
		if (rst || restart_mode) begin
			m0 <= WAKE_W'(MASK_RESET); // R20
			m1 <= FA_W'(MASK_RESET);
			m2 <= FB_W'(MASK_RESET);
		end else if (mask_wr) begin
			if (mask_addr == ADDR_WAKE_SUM) m0 <= mask_wdata[WAKE_W-1:0]; // R2
			if (mask_addr == ADDR_FAULT_A) m1 <= mask_wdata[FA_W-1:0];
			if (mask_addr == ADDR_FAULT_B) m2 <= mask_wdata[FB_W-1:0];
		end
	end

	always_comb begin
		next_rd_data = 8'h00;
		unique case (rd_addr)
			ADDR_WAKE_SUM: begin
				next_rd_data[WAKE_W-1:0] = f0;
				next_rd_data[SUMMARY_BIT] = summary; // R8
			end
			ADDR_FAULT_A: next_rd_data[FA_W-1:0] = f1;
			ADDR_FAULT_B: next_rd_data[FB_W-1:0] = f2;
			default: next_rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else if (rd_only) begin
			rd_data <= next_rd_data;
		end
	end

	// Pin synchroniser and configuration strap during init
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
		end else begin
			pin_meta <= attn_in;
			pin_sync <= pin_meta;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg_alt <= 1'b0;
		end else if (!reset_line_n) begin
			cfg_alt <= pin_sync; // R11
		end
	end

	// Pending interrupt; merged into the pulse only before the release read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pend <= 1'b0;
		end else begin
			pend <= (trig && (state == SIU_GAP || (state == SIU_LOW && (rel_req || rd0)))) ||
				(pend && (state != SIU_IDLE || !active)); // R18 R21
		end
	end

	// Release request from a register 0 read
	always_ff @(posedge sys_clk) begin
		if (rst || state != SIU_LOW) begin
			rel_req <= 1'b0;
		end else if (rd0) begin
			rel_req <= 1'b1; // R6 R17
		end
	end

	// Attention sequencer; cnt runs from activation start
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= SIU_IDLE;
			cnt <= '0;
		end else begin
			unique case (state)
				SIU_IDLE: begin
					cnt <= '0;
					if (active && (pend || trig)) state <= SIU_LOW; // R1 R21
				end
				SIU_LOW: begin
					cnt <= cnt + 1'b1; // R16
					if ((rel_req && cnt >= MIN_LAST) || cnt >= TO_LAST) begin
						state <= SIU_GAP; // R6 R18 R19
					end
				end
				SIU_GAP: begin
					cnt <= cnt + 1'b1;
					if (cnt >= TO_LAST) state <= SIU_IDLE; // R18
				end
			endcase
		end
	end

	assign attn_out = 1'b0;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			attn_oe <= 1'b0;
		end else begin
			attn_oe <= (state == SIU_IDLE && active && (pend || trig)) ||
				(state == SIU_LOW && !((rel_req && cnt >= MIN_LAST) || cnt >= TO_LAST));
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_pin_on_trigger: assert property (state == SIU_IDLE && active && trig |=> attn_oe) // R1
		else $error("attention not driven after unmasked event");
	a_mask_gates_pin: assert property (state == SIU_IDLE && !pend && active &&
		fa_rise != 0 && (fa_rise & m1) == 0 && wk_rise == 0 && fb_trig == 0 |=> !attn_oe) // R2
		else $error("masked source drove attention");
	a_mask_keeps_flag: assert property (fa_rise[0] && !m1[0] |=> f1[0]) // R2
		else $error("masked flag not set");
	a_wake_cleared: assert property (rd0 && wk_rise == 0 |=> f0 == 0) // R7
		else $error("wake flags not cleared by read");
	a_event_cleared: assert property (rd2 && fb_rise[FB_W-1:FB_UV_W] == 0
		|=> f2[FB_W-1:FB_UV_W] == 0) // R9
		else $error("event flags not cleared by read");
	a_state_latched: assert property (f1[1] && !rd1 |=> f1[1]) // R4
		else $error("latched fault lost without read");
	a_summary_value: assert property (rd0 |=> rd_data[SUMMARY_BIT] == $past(|f1 || |f2)) // R10
		else $error("summary bit wrong");
	a_switch_on_flag: assert property (third_supply_on // R12
		|=> f2[FB_THIRD_LOW] ##1 (f2[FB_THIRD_LOW] || $past(rd2)))
		else $error("switch-on flag missing");
	a_uv_sticks: assert property (rd2 && uv_eff[1] |=> f2[FB_THIRD_LOW]) // R13
		else $error("undervoltage flag cleared while low");
	a_min_pulse: assert property ($fell(attn_oe) |-> $past(cnt) >= MIN_LAST) // R19
		else $error("attention pulse too short");
	a_timeout_bound: assert property (attn_oe |-> cnt <= TO_LAST) // R18
		else $error("attention low beyond timeout");
	a_init_input: assert property (!reset_line_n |-> !attn_oe ##1 !attn_oe) // R11
		else $error("attention driven during init");
	a_restart_unmask: assert property (restart_mode |=> m0 == '1 && m1 == '1 && m2 == '1) // R20
		else $error("restart did not unmask sources");
	a_release_read: assert property (state == SIU_LOW && rd0 && cnt >= MIN_LAST
		&& cnt < TO_LAST |=> ##1 !attn_oe) // R6
		else $error("read did not release attention");

	c_wake_read: cover property (f0[0] ##[1:20] rd0);
	c_timeout: cover property (state == SIU_LOW && cnt >= TO_LAST);
	c_merged: cover property (state == SIU_LOW && trig);
	c_second_irq: cover property (state == SIU_GAP && pend);

endmodule : siu_interrupt_unit

// ---- siu_pkg.sv ----
// Purpose: Shared constants of the attention-line interrupt unit
// Assumes: 25 MHz system clock from the on-chip oscillator
// Notes: Flag and mask registers share one bit layout per address
package siu_pkg;

	// Register addresses of read-only accesses
	localparam logic [2:0] ADDR_WAKE_SUM = 3'h0;
	localparam logic [2:0] ADDR_FAULT_A = 3'h1;
	localparam logic [2:0] ADDR_FAULT_B = 3'h2;

	// Field layout, wake and summary register
	localparam int WAKE_W = 4;
	localparam int SUMMARY_BIT = 7;
	// Bits 0..3: bus wake, single-wire wake, local pin wake, periodic wake

	// Field layout, fault register A (all state-type)
	localparam int FA_W = 6;
	// Bits 0..5: prewarn, thermal shutdown, transceiver overheat,
	// bus failure, single-wire failure, third supply overcurrent

	// Field layout, fault register B
	localparam int FB_W = 5;
	localparam int FB_AUX_LOW = 0;
	localparam int FB_THIRD_LOW = 1;
	localparam int FB_SPI_BAD = 2;
	localparam int FB_RESET = 3;
	localparam int FB_GUARD = 4;
	localparam int FB_UV_W = 2;

	// Reset values
	localparam logic [7:0] MASK_RESET = 8'hFF;
	localparam logic [7:0] FLAG_RESET = 8'h00;

	// Timing
	localparam int OSC_FREQ_KHZ = 25000;
	localparam int OSC_TOL_PCT = 10;
	localparam int TIMEOUT_US = 6000;
	localparam int MIN_PULSE_US = 10;
	localparam int TIMEOUT_CYC = TIMEOUT_US * OSC_FREQ_KHZ / 1000;
	localparam int MIN_PULSE_CYC = (MIN_PULSE_US * OSC_FREQ_KHZ + 999) / 1000;
	localparam int CNT_W = 18;

	typedef enum logic [2:0] {
		SIU_IDLE = 3'b001,
		SIU_LOW = 3'b010,
		SIU_GAP = 3'b100
	} siu_state_e;

endpackage : siu_pkg

// ---- tb_sbc_interrupt_unit.sv ----
// Purpose: Self-checking bench of the attention-line interrupt unit
// Assumes: Inputs change on the falling edge; timeout shortened to 400
// Notes: Low pulse lengths are measured in clock cycles
module tb_sbc_interrupt_unit;
	timeunit 1ns;
	timeprecision 1ps;
	import siu_pkg::*;
	localparam int TO = 400;
	logic sys_clk = 1'b0, rst = 1'b1, rl_n = 1'b0, devm = 1'b0, rstrt = 1'b0;
	logic mwr = 1'b0, cfg_en = 1'b1, cfg_lv = 1'b1;
	logic [5:0] evt = 6'h00, fa = 6'h00, f;
	logic [1:0] uvl = 2'h0;
	logic [3:0] sw = 4'h0;
	logic [2:0] maddr = 3'h0, rd_addr;
	logic [7:0] mdat = 8'h00, rd_data, d;
	logic rd_only, attn_out, attn_oe, cfg_alt, pin;
	int fails = 0, num_checks = 0, cyc = 0, run = 0, last_len = 0, pulses = 0, p0;
	siu_interrupt_unit #(.TIMEOUT_CYCLES(TO)) dut_u (
		.sys_clk(sys_clk), .rst(rst), .reset_line_n(rl_n), .sw_dev_mode(devm),
		.restart_mode(rstrt), .bus_wake_flag(evt[0]), .single_wire_wake_flag(evt[1]),
		.local_pin_wake_flag(evt[2]), .periodic_wake_flag(evt[3]), .prewarn_temp(fa[0]),
		.thermal_shutdown_flag(fa[1]), .bus_transceiver_overheat(fa[2]), .bus_fault(fa[3]),
		.single_wire_fault_flag(fa[4]), .third_supply_overcurrent(fa[5]),
		.aux_supply_low_flag(uvl[0]), .third_supply_low_flag(uvl[1]), .aux_supply_on(sw[0]),
		.aux_supply_off(sw[1]), .third_supply_on(sw[2]), .third_supply_off(sw[3]),
		.spi_frame_bad(evt[4]), .bad_guard_config_flag(evt[5]), .rd_only(rd_only),
		.rd_addr(rd_addr), .rd_data(rd_data), .mask_wr(mwr), .mask_addr(maddr),
		.mask_wdata(mdat), .attn_in(pin), .attn_out(attn_out), .attn_oe(attn_oe),
		.cfg_alt(cfg_alt));
	siu_host_model host_u (.sys_clk(sys_clk), .attn_out(attn_out), .attn_oe(attn_oe),
		.cfg_en(cfg_en), .cfg_level(cfg_lv), .rd_data(rd_data), .attn_pin(pin),
		.rd_only(rd_only), .rd_addr(rd_addr));
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (attn_oe === 1'b1) begin
			run++;
		end else if (run != 0) begin
			last_len = run;
			pulses++;
			run = 0;
		end
		if (cyc > 20000) begin
			fails++;
			results();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick
	task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string s);
		host_u.rd(a, d);
		chk(s, e, d);
	endtask : rdc
	function automatic logic [7:0] loc_bit(input int i);
		return i < 4 ? 8'(1 << i) : (i == 4 ? 8'(1 << FB_SPI_BAD) : 8'(1 << FB_GUARD));
	endfunction : loc_bit
	task automatic results();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	initial begin
		void'($urandom(32'h9193));
		tick(4);
		rst = 1'b0;
		tick(4);
		chk("cfg_alt", 1, cfg_alt);
		chk("init drive", 0, attn_oe);
		cfg_en = 1'b0;
		rl_n = 1'b1;
		tick(4);
		$display("test init done");
		for (int i = 0; i < 6; i++) begin
			p0 = pulses;
			evt[i] = 1'b1;
			tick(3);
			chk("pin low", 0, pin);
			rdc(ADDR_WAKE_SUM, i < 4 ? loc_bit(i) : 8'h80, "reg0");
			if (i > 3) rdc(ADDR_FAULT_B, loc_bit(i), "reg2");
			rdc(i < 4 ? ADDR_WAKE_SUM : ADDR_FAULT_B, 8'h00, "cleared");
			rdc(ADDR_WAKE_SUM, 8'h00, "summary");
			evt[i] = 1'b0;
			tick(TO + 20);
			chk("min pulse", 1, last_len >= 250 && last_len <= 260);
			chk("pulse count", p0 + 1, pulses);
		end
		$display("test events done");
		evt[0] = 1'b1;
		tick(TO + 20);
		chk("timeout", 1, last_len >= TO && last_len <= TO + 1);
		rdc(ADDR_WAKE_SUM, 8'h01, "kept");
		evt[0] = 1'b0;
		tick(TO);
		evt[1] = 1'b1;
		tick(3);
		rdc(ADDR_WAKE_SUM, 8'h02, "wake1");
		tick(280);
		evt[2] = 1'b1;
		tick(30);
		chk("gap", 0, attn_oe);
		tick(TO - 280);
		chk("pended", 1, attn_oe);
		rdc(ADDR_WAKE_SUM, 8'h04, "wake2");
		evt[2:1] = 2'b00;
		tick(TO + 20);
		$display("test timeout done");
		mwr = 1'b1;
		tick(1);
		maddr = ADDR_FAULT_A;
		tick(1);
		mwr = 1'b0;
		evt[3] = 1'b1;
		tick(5);
		chk("masked", 0, attn_oe);
		rdc(ADDR_WAKE_SUM, 8'h08, "masked flag");
		fa[0] = 1'b1;
		tick(2);
		fa[0] = 1'b0;
		tick(2);
		chk("masked fault", 0, attn_oe);
		rdc(ADDR_FAULT_A, 8'h01, "masked fault flag");
		evt[3] = 1'b0;
		rstrt = 1'b1;
		tick(2);
		rstrt = 1'b0;
		evt[3] = 1'b1;
		tick(3);
		chk("restart", 1, attn_oe);
		rdc(ADDR_WAKE_SUM, 8'h08, "rewake");
		evt[3] = 1'b0;
		tick(TO + 20);
		$display("test mask done");
		evt[0] = 1'b1;
		tick(300);
		rdc(ADDR_WAKE_SUM, 8'h01, "late read");
		chk("late release", 0, attn_oe);
		evt[0] = 1'b0;
		tick(TO + 20);
		chk("late len", 1, last_len >= 300 && last_len <= 305);
		$display("test late read done");
		f = 6'($urandom()) | 6'h01;
		p0 = pulses;
		fa = f;
		tick(3);
		rdc(ADDR_WAKE_SUM, 8'h80, "sum set");
		repeat (2) rdc(ADDR_FAULT_A, {2'b00, f}, "state");
		fa = 6'h00;
		rdc(ADDR_FAULT_A, {2'b00, f}, "state held");
		rdc(ADDR_FAULT_A, 8'h00, "state gone");
		rdc(ADDR_WAKE_SUM, 8'h00, "sum gone");
		tick(TO + 20);
		chk("merged", p0 + 1, pulses);
		$display("test faults done");
		p0 = pulses;
		uvl[1] = 1'b1;
		sw[2] = 1'b1;
		tick(1);
		sw[2] = 1'b0;
		tick(2);
		chk("switch on", 1, attn_oe);
		repeat (2) rdc(ADDR_FAULT_B, 8'h02, "stuck");
		rdc(ADDR_WAKE_SUM, 8'h80, "sum uv");
		uvl[1] = 1'b0;
		tick(2 * TO + 40);
		chk("uv release irq", p0 + 2, pulses);
		host_u.rd(ADDR_FAULT_B, d);
		rdc(ADDR_FAULT_B, 8'h00, "uv gone");
		p0 = pulses;
		sw[3] = 1'b1;
		tick(1);
		sw[3] = 1'b0;
		uvl[1] = 1'b1;
		tick(5);
		chk("switch off", p0, pulses + (attn_oe === 1'b1));
		$display("test supply done");
		rl_n = 1'b0;
		tick(3);
		rl_n = 1'b1;
		tick(2);
		rdc(ADDR_FAULT_B, 8'h00, "no dev reset");
		devm = 1'b1;
		rl_n = 1'b0;
		tick(3);
		chk("init quiet", 0, attn_oe);
		chk("cfg hold", 1, cfg_alt);
		rl_n = 1'b1;
		tick(2);
		rdc(ADDR_FAULT_B, 8'h08, "dev reset");
		$display("test reset source done");
		results();
	end
endmodule : tb_sbc_interrupt_unit
